//--- bench/sdc_mem_model.sv
`timescale 1ns/1ns
`include "sdc_consts.svh"
module sdc_mem_model #(
    parameter int P_POWER_CYC = 20
)(
    input  wire logic        clk,
    input  wire logic        cke,
    input  wire logic [3:0]  cmd,
    input  wire logic [1:0]  ba,
    input  wire logic [12:0] a,
    input  wire logic        dqm,
    input  wire logic [15:0] dq_in,
    input  wire logic        dq_oe,
    output logic      [15:0] dq_out = 16'h5A5A
);
    logic [15:0] mem [0:1023];
    logic [13:0] mode = 14'h3FFF; // Garbage until the first load
    logic [9:0]  start = 10'h0;
    logic        open = 1'h0;
    logic [1:0]  act_ba = 2'h0;
    logic [12:0] act_row = 13'h0;
    int          errs = 0, pwr = 0, stage = 0, gap = 99, len = 1;
    int          rd_wait = 0, rd_left = 0, wr_left = 0, beat = 0;

    function automatic logic [9:0] col_of(logic [9:0] s, int k, logic [13:0] m);
        int n;
        n = (m[2:0] == 3'h7) ? 1024 : (1 << m[2:0]);
        if (m[3]) return s ^ 10'(k);
        return (s & ~10'(n - 1)) | ((s + 10'(k)) & 10'(n - 1));
    endfunction

    initial begin
        for (int i = 0; i < 1024; i++) mem[i] = 16'hA000 | 16'(i);
    end

    ////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        pwr = cke ? pwr + 1 : 0;
        gap++;
        len = (mode[2:0] == 3'h7) ? 1024 : (1 << mode[2:0]);
        dq_out <= ~dq_out; // Released bus drifts, never keeps old data
        if (rd_left > 0 && rd_wait > 0) begin
            rd_wait--;
        end else if (rd_left > 0) begin
            dq_out <= mem[col_of(start, beat, mode)];
            beat++;
            rd_left--;
        end
        if (wr_left > 0 && cmd != `SDC_CMD_BST) begin
            if (!dq_oe) errs++;
            if (!dqm) mem[col_of(start, beat, mode)] = dq_in;
            beat++;
            wr_left--;
        end
        if (cmd != `SDC_CMD_INHIBIT && cmd != `SDC_CMD_NOP) begin
            if (pwr < P_POWER_CYC || gap < 2) errs++;
            case (cmd)
                `SDC_CMD_PRE: begin
                    if (a[10] && stage == 0) stage = 1;
                    if (a[10]) open = 1'h0;
                end
                `SDC_CMD_REF: if (cke && (stage == 1 || stage == 2)) stage++;
                `SDC_CMD_LMR: begin
                    if (open || stage < 3 || ba != 2'h0) errs++;
                    if (a[12:10] != 3'h0 || a[8:7] != 2'h0 || a[6:5] != 2'h1) errs++;
                    if (a[2] && (a[1:0] != 2'h3 || a[3])) errs++;
                    mode = {1'h0, a};
                    stage = 4;
                    gap = 0;
                end
                `SDC_CMD_ACTIVE: begin
                    if (stage < 4 || open) errs++;
                    open = 1'h1;
                    act_ba = ba;
                    act_row = a;
                end
                `SDC_CMD_READ, `SDC_CMD_WRITE: begin
                    if (!open || ba != act_ba) errs++;
                    start = a[9:0];
                    beat = (cmd == `SDC_CMD_WRITE) ? 1 : 0;
                    rd_wait = int'(mode[6:4]) - 2;
                    if (cmd == `SDC_CMD_READ) rd_left = len;
                    else if (!dqm) mem[col_of(start, 0, mode)] = dq_in;
                    wr_left = (cmd == `SDC_CMD_READ || mode[9]) ? 0 : len - 1;
                end
                `SDC_CMD_BST: begin
                    if (rd_left > int'(mode[6:4]) - 2) rd_left = int'(mode[6:4]) - 2;
                    wr_left = 0;
                end
                default: errs++;
            endcase
        end
    end
endmodule

//--- bench/sdram_init_mode_burst_test.sv
`timescale 1ns/1ns
`include "sdc_consts.svh"
module sdram_init_mode_burst_test;
    localparam int P_PWR = 20;
    localparam logic [7:0][13:0] MODES = {14'h0027, 14'h0222, 14'h0020, 14'h0021,
                                          14'h002B, 14'h0033, 14'h003A, 14'h0022};
    localparam logic [7:0][9:0] COLS = {10'h1FA, 10'h042, 10'h3FF, 10'h011,
                                        10'h2F3, 10'h0C6, 10'h105, 10'h001};
    localparam logic [3:0][13:0] BAD = {14'h00A2, 14'h0012, 14'h002F, 14'h0024};
    logic        sys_clk, rst, reg_wr, reg_rd, cke, cs_n, ras_n, cas_n, we_n, dqm, dq_oe, ce;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic [1:0]  ba;
    logic [12:0] a;
    logic [15:0] dq_mem, dq_ctl, dq_wire;
    logic [15:0] shadow [0:1023];
    int          n_fail, n_checks;

    assign dq_wire = dq_oe ? dq_ctl : dq_mem;

    sdc_ctrl #(.P_POWER_CYC(P_PWR)) dut (
        .SYS_CLK(sys_clk), .RST(rst), .CE(ce), .REG_ADDR(reg_addr),
        .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
        .SD_CKE(cke), .SD_CS_N(cs_n), .SD_RAS_N(ras_n), .SD_CAS_N(cas_n), .SD_WE_N(we_n),
        .SD_BA(ba), .SD_A(a), .SD_DQM(dqm), .SD_DQ_I(dq_wire), .SD_DQ_O(dq_ctl),
        .SD_DQ_OE(dq_oe));

    sdc_mem_model #(.P_POWER_CYC(P_PWR)) model (
        .clk(sys_clk), .cke(cke), .cmd({cs_n, ras_n, cas_n, we_n}), .ba(ba), .a(a),
        .dqm(dqm), .dq_in(dq_wire), .dq_oe(dq_oe), .dq_out(dq_mem));

    ////////////////////////////////////////////////////////////////
    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(logic [7:0] ad, logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= ad;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge sys_clk);
        reg_wr <= 1'h0;
    endtask

    task automatic rd(logic [7:0] ad, output logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= ad;
        reg_rd <= 1'h1;
        @(posedge sys_clk);
        reg_rd <= 1'h0;
        #1;
        d = reg_rdata;
    endtask

    task automatic wait_idle();
        logic [31:0] s;
        for (int i = 0; i < 200; i++) begin
            rd(`SDC_REG_STAT, s);
            if (s[`SDC_STB_DONE] === 1'h1 && s[`SDC_STB_BUSY] === 1'h0) return;
        end
        check("idle wait", 32'h0, 32'h1);
    endtask

    function automatic logic [9:0] col_exp(logic [9:0] s, int k, logic [13:0] m);
        int n;
        n = (m[2:0] == 3'h7) ? 1024 : (1 << m[2:0]);
        if (m[3]) return s ^ 10'(k);
        return (s & ~10'(n - 1)) | ((s + 10'(k)) & 10'(n - 1));
    endfunction

    ////////////////////////////////////////////////////////////////
    task automatic t_init();
        logic [31:0] d;
        wait_idle();
        check("init stage", 32'(model.stage), 32'h4);
        rd(`SDC_REG_MODE, d);
        check("mode after init", d, 32'h00220022);
        check("device mode", {18'h0, model.mode}, 32'h0022);
        rd(8'h50, d);
        check("unmapped read", d, 32'h0);
        // Clock enable low: register strobes must be ignored, read data held
        @(posedge sys_clk);
        ce <= 1'h0;
        wr(`SDC_REG_MODE, 32'h0000_0021);
        rd(`SDC_REG_STAT, d);
        @(posedge sys_clk);
        ce <= 1'h1;
        check("frozen read", d, 32'h0);
        rd(`SDC_REG_MODE, d);
        check("frozen mode", d, 32'h00220022);
    endtask

    task automatic t_refuse();
        logic [31:0] d;
        for (int i = 0; i < 4; i++) begin
            wr(`SDC_REG_MODE, {18'h0, BAD[i]});
            rd(`SDC_REG_STAT, d);
            check("bad mode flag", {31'h0, d[`SDC_STB_MODE_ERR]}, 32'h1);
            wr(`SDC_REG_STAT, 32'h4);
            rd(`SDC_REG_MODE, d);
            check("bad mode kept out", d, 32'h00220022);
        end
    endtask

    task automatic t_burst(logic [13:0] m, logic [9:0] c);
        logic [31:0] d;
        logic [9:0]  cx;
        int          n;
        n = (m[2:0] == 3'h7) ? 8 : (1 << m[2:0]);
        wr(`SDC_REG_MODE, {18'h0, m});
        wr(`SDC_REG_CMD, 32'h4);
        wait_idle();
        check("device mode", {18'h0, model.mode}, {18'h0, m});
        for (int i = 0; i < 8; i++) wr(8'h20 + 8'(4 * i), {16'h0, m[5:0], c[6:0], 3'(i)});
        wr(`SDC_REG_ADDR, {7'h0, 2'h2, 13'h0155, c});
        wr(`SDC_REG_CMD, 32'h2);
        wr(`SDC_REG_CMD, 32'h1);
        rd(`SDC_REG_STAT, d);
        check("busy refusal", {31'h0, d[`SDC_STB_REQ_ERR]}, 32'h1);
        wr(`SDC_REG_STAT, 32'h8);
        wait_idle();
        check("opened row", {17'h0, model.act_ba, model.act_row}, {17'h0, 2'h2, 13'h0155});
        for (int k = 0; k < n; k++) begin
            cx = col_exp(c, k, m);
            if (k == 0 || !m[9]) shadow[cx] = {m[5:0], c[6:0], cx[2:0]};
            check("cell written", {16'h0, model.mem[cx]}, {16'h0, shadow[cx]});
        end
        for (int i = 0; i < 8; i++) wr(8'h20 + 8'(4 * i), 32'h0);
        wr(`SDC_REG_CMD, 32'h1);
        wait_idle();
        for (int k = 0; k < n; k++) begin
            cx = col_exp(c, k, m);
            rd(8'h20 + {3'h0, cx[2:0], 2'h0}, d);
            check("read beat", d, {16'h0, shadow[cx]});
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'h0;
        forever #5 sys_clk = ~sys_clk;
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        n_fail++;
        print_verdict();
    end

    initial begin
        rst = 1'h1;
        ce = 1'h1;
        reg_wr = 1'h0;
        reg_rd = 1'h0;
        reg_addr = 8'h0;
        reg_wdata = 32'h0;
        n_fail = 0;
        n_checks = 0;
        for (int i = 0; i < 1024; i++) shadow[i] = 16'hA000 | 16'(i);
        repeat (4) @(posedge sys_clk);
        check("cke in reset", {31'h0, cke}, 32'h0);
        check("cmd in reset", {28'h0, cs_n, ras_n, cas_n, we_n}, 32'hF);
        rst <= 1'h0;
        t_init();
        t_refuse();
        for (int i = 0; i < 8; i++) t_burst(MODES[i], COLS[i]);
        check("protocol errors", 32'(model.errs), 32'h0);
        print_verdict();
    end
endmodule

//--- src/sdc_burst_order.sv
`timescale 1ns/1ns
`include "sdc_consts.svh"
module sdc_burst_order
    import sdc_pkg::*;
(
    input  wire logic [9:0] start_col,
    input  wire logic [2:0] beat,
    input  wire logic [2:0] bl_code,
    input  wire logic       interleaved,
    output logic      [9:0] col
);
    logic [2:0] sum_lo;
    logic [2:0] xor_lo;
    logic [2:0] lo;
    logic [9:0] page_col;

    assign sum_lo   = start_col[2:0] + beat;
    assign xor_lo   = start_col[2:0] ^ beat;
    assign page_col = start_col + {7'h00, beat};

    // Bits below the block size move, the rest pick the block
    genvar i;
    for (i = 0; i < 3; i++) begin : g_bit
        assign lo[i] = (3'(i) < bl_code) ? (interleaved ? xor_lo[i] : sum_lo[i])
                                         : start_col[i];
    end

    assign col = (bl_code == `SDC_BL_FULL) ? page_col : {start_col[9:3], lo};

endmodule

//--- src/sdc_consts.svh
`ifndef SDC_CONSTS_SVH
`define SDC_CONSTS_SVH
// Function
// - ACTIVE with bank and row before access
// - Wait 100 us before real commands
// - Only NOP or inhibit during power wait
// - Precharge all banks after power wait
// - Two auto refreshes before mode load
// - Load mode before any operational command
// - Mode bits twelve and thirteen zero
// - Load only idle, then wait load delay
// - Operating mode bits programmed zero
// - Never program reserved length or type
// - Mode load: all low, bank bits select register

// Command code {cs_n, ras_n, cas_n, we_n}
`define SDC_CMD_INHIBIT 4'hF
`define SDC_CMD_NOP     4'h7
`define SDC_CMD_BST     4'h6
`define SDC_CMD_READ    4'h5
`define SDC_CMD_WRITE   4'h4
`define SDC_CMD_ACTIVE  4'h3
`define SDC_CMD_PRE     4'h2
`define SDC_CMD_REF     4'h1
`define SDC_CMD_LMR     4'h0

// Register byte offsets
`define SDC_REG_CMD   8'h00
`define SDC_REG_MODE  8'h04
`define SDC_REG_ADDR  8'h08
`define SDC_REG_STAT  8'h0C
`define SDC_BUF_PAGE  3'h1
`define SDC_CMDB_RD     0
`define SDC_CMDB_WR     1
`define SDC_CMDB_RELOAD 2
`define SDC_STB_DONE     0
`define SDC_STB_BUSY     1
`define SDC_STB_MODE_ERR 2
`define SDC_STB_REQ_ERR  3

// Mode field layout
`define SDC_M_BL_MSB  2
`define SDC_M_TYPE    3
`define SDC_M_LAT_MSB 6
`define SDC_M_LAT_LSB 4
`define SDC_M_OPM_MSB 8
`define SDC_M_OPM_LSB 7
`define SDC_M_WSINGLE 9
`define SDC_MODE_RST  14'h0022
`define SDC_BL_FULL   3'h7

// Timing
`define SDC_CLK_MHZ    100
`define SDC_POWER_US   100
`define SDC_POWER_CYC  (`SDC_POWER_US * `SDC_CLK_MHZ)
`define SDC_T_RP_NS    20
`define SDC_T_RFC_NS   80
`define SDC_T_MRD_NS   20
`define SDC_T_RCD_NS   20
`define SDC_T_WR_NS    15
`define SDC_CYC(ns)    ((((ns) * `SDC_CLK_MHZ) + 999) / 1000)
`define SDC_RP_CYC     16'(`SDC_CYC(`SDC_T_RP_NS))
`define SDC_RFC_CYC    16'(`SDC_CYC(`SDC_T_RFC_NS))
`define SDC_MRD_CYC    16'(`SDC_CYC(`SDC_T_MRD_NS))
`define SDC_RCD_CYC    16'(`SDC_CYC(`SDC_T_RCD_NS))
`define SDC_WR_CYC     16'(`SDC_CYC(`SDC_T_WR_NS))

`endif

//--- src/sdc_ctrl.sv
`timescale 1ns/1ns
`include "sdc_consts.svh"
module sdc_ctrl
    import sdc_pkg::*;
#(
    parameter int P_POWER_CYC = `SDC_POWER_CYC
)(
    input  wire logic        SYS_CLK,
    input  wire logic        RST,
    input  wire logic        CE,
    input  wire logic [7:0]  REG_ADDR,
    input  wire logic [31:0] REG_WDATA,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    output logic      [31:0] REG_RDATA,
    output logic             SD_CKE,
    output logic             SD_CS_N,
    output logic             SD_RAS_N,
    output logic             SD_CAS_N,
    output logic             SD_WE_N,
    output logic      [1:0]  SD_BA,
    output logic      [12:0] SD_A,
    output logic             SD_DQM,
    input  wire logic [15:0] SD_DQ_I,
    output logic      [15:0] SD_DQ_O,
    output logic             SD_DQ_OE
);
    sdc_regs_t   q;
    sdc_regs_t   d;
    logic [9:0]  beat_col;
    logic [3:0]  nbeats;
    logic [2:0]  bl_code;
    logic [2:0]  lat;
    logic        full_page;

    ////////////////////////////////////////////////////////////////////////////
    // Active mode decode

    assign bl_code   = q.mode_act[`SDC_M_BL_MSB:0];
    assign lat       = q.mode_act[`SDC_M_LAT_MSB:`SDC_M_LAT_LSB];
    assign full_page = (bl_code == `SDC_BL_FULL);

    always_comb begin
        if (q.is_wr && q.mode_act[`SDC_M_WSINGLE]) begin
            nbeats = 4'h1;
        end else if (full_page) begin
            nbeats = 4'h8;                          // Page burst cut at buffer depth
        end else begin
            nbeats = 4'(4'h1 << bl_code);
        end
    end

    sdc_burst_order u_order (
        .start_col   (q.col),
        .beat        (q.beat[2:0]),
        .bl_code     (bl_code),
        .interleaved (q.mode_act[`SDC_M_TYPE]),
        .col         (beat_col)
    );

    function automatic logic mode_legal(input logic [13:0] m);
        logic bl_ok;
        logic lat_ok;
        bl_ok  = (m[`SDC_M_BL_MSB:0] < 3'h4) ||
                 (m[`SDC_M_BL_MSB:0] == `SDC_BL_FULL && !m[`SDC_M_TYPE]);
        lat_ok = (m[`SDC_M_LAT_MSB:`SDC_M_LAT_LSB] == 3'h2) ||
                 (m[`SDC_M_LAT_MSB:`SDC_M_LAT_LSB] == 3'h3);
        return bl_ok && lat_ok && (m[`SDC_M_OPM_MSB:`SDC_M_OPM_LSB] == 2'h0);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        d       = q;
        d.cmd   = `SDC_CMD_NOP;
        d.rdata = 32'h0000_0000;

        // Status clear first, so a same-cycle set wins
        if (REG_WR && REG_ADDR == `SDC_REG_STAT) begin
            if (REG_WDATA[`SDC_STB_MODE_ERR]) d.mode_err = 1'b0;
            if (REG_WDATA[`SDC_STB_REQ_ERR])  d.req_err  = 1'b0;
        end
        if (REG_WR && REG_ADDR == `SDC_REG_MODE) begin
            // Top bits 13:10 forced low; only written bits 9:0 are kept
            if (mode_legal(REG_WDATA[13:0])) begin
                d.mode_pend = {4'h0, REG_WDATA[9:0]};
            end else begin
                d.mode_err  = 1'b1;
            end
        end
        if (REG_WR && REG_ADDR == `SDC_REG_ADDR) begin
            d.col  = REG_WDATA[9:0];
            d.row  = REG_WDATA[22:10];
            d.bank = REG_WDATA[24:23];
        end
        if (REG_WR && REG_ADDR[7:5] == `SDC_BUF_PAGE) begin
            d.dbuf[REG_ADDR[4:2]] = REG_WDATA[15:0];
        end

        case (q.st)
            S_POWER: begin
                d.cke = 1'b1;
                if (q.cnt >= 16'(P_POWER_CYC - 1)) begin
                    d.st = S_PREALL;
                end else begin
                    d.cnt = q.cnt + 16'h0001;
                end
            end
            S_PREALL: begin
                d.cmd  = `SDC_CMD_PRE;
                d.a    = 13'h0400;
                d.refs = 2'h0;
                d.cnt  = `SDC_RP_CYC - 16'h0001;
                d.ret  = S_REFRESH;
                d.st   = S_WAIT;
            end
            S_REFRESH: begin
                d.cmd  = `SDC_CMD_REF;
                d.refs = q.refs + 2'h1;
                d.cnt  = `SDC_RFC_CYC - 16'h0001;
                d.ret  = (q.refs == 2'h1) ? S_LOAD : S_REFRESH;
                d.st   = S_WAIT;
            end
            S_LOAD: begin
                // Whole op-code presented in one command cycle
                d.cmd      = `SDC_CMD_LMR;
                d.ba       = 2'h0;
                d.a        = {3'h0, q.mode_pend[9:0]};
                d.mode_act = q.mode_pend;
                d.done     = 1'b1;
                d.cnt      = `SDC_MRD_CYC - 16'h0001;
                d.ret      = S_IDLE;
                d.st       = S_WAIT;
            end
            S_ACTIVE: begin
                d.cmd = `SDC_CMD_ACTIVE;
                d.ba  = q.bank;
                d.a   = q.row;
                d.cnt = `SDC_RCD_CYC - 16'h0001;
                d.ret = S_ACCESS;
                d.st  = S_WAIT;
            end
            S_ACCESS: begin
                d.ba  = q.bank;
                d.a   = {3'h0, q.col};                  // No auto precharge
                d.dqm = 1'b0;
                d.cnt = 16'h0000;
                if (q.is_wr) begin
                    d.cmd   = `SDC_CMD_WRITE;
                    // Beat counter still holds the last burst; beat 0 is the start column
                    d.dq_o  = q.dbuf[q.col[2:0]];
                    d.dq_oe = 1'b1;
                    d.beat  = 4'h1;
                    d.st    = S_WDATA;
                end else begin
                    d.cmd  = `SDC_CMD_READ;
                    d.beat = 4'h0;
                    d.st   = S_RDATA;
                end
            end
            S_RDATA: begin
                if (q.cnt < {13'h0000, lat}) begin
                    d.cnt = q.cnt + 16'h0001;
                end else begin
                    // Sampled at edge n + latency
                    d.dbuf[beat_col[2:0]] = SD_DQ_I;
                    d.beat = q.beat + 4'h1;
                    if (q.beat == nbeats - 4'h1) begin
                        if (full_page) d.cmd = `SDC_CMD_BST;
                        d.st = S_CLOSE;
                    end
                end
            end
            S_WDATA: begin
                if (q.beat == nbeats) begin
                    d.dq_oe = 1'b0;
                    if (full_page && !q.mode_act[`SDC_M_WSINGLE]) d.cmd = `SDC_CMD_BST;
                    d.cnt = `SDC_WR_CYC - 16'h0001;
                    d.ret = S_CLOSE;
                    d.st  = S_WAIT;
                end else begin
                    d.dq_o = q.dbuf[beat_col[2:0]];
                    d.beat = q.beat + 4'h1;
                end
            end
            S_CLOSE: begin
                d.cmd = `SDC_CMD_PRE;
                d.a   = 13'h0400;
                d.dqm = 1'b1;
                d.cnt = `SDC_RP_CYC - 16'h0001;
                d.ret = S_IDLE;
                d.st  = S_WAIT;
            end
            S_WAIT: begin
                if (q.cnt <= 16'h0001) begin
                    d.st = q.ret;
                end else begin
                    d.cnt = q.cnt - 16'h0001;
                end
            end
            S_IDLE: begin
                d.dqm = 1'b1;
            end
            default: begin
                d.st = S_POWER;
            end
        endcase

        // Requests only taken idle and initialised; else flagged
        if (REG_WR && REG_ADDR == `SDC_REG_CMD && REG_WDATA[2:0] != 3'h0) begin
            if (q.st != S_IDLE || !q.done) begin
                d.req_err = 1'b1;
            end else if (REG_WDATA[`SDC_CMDB_RELOAD]) begin
                d.st = S_LOAD;
            end else begin
                d.is_wr = REG_WDATA[`SDC_CMDB_WR];
                d.st    = S_ACTIVE;
            end
        end

        if (REG_RD) begin
            case (REG_ADDR)
                `SDC_REG_MODE: d.rdata = {2'h0, q.mode_act, 2'h0, q.mode_pend};
                `SDC_REG_ADDR: d.rdata = {7'h00, q.bank, q.row, q.col};
                `SDC_REG_STAT: d.rdata = {28'h0000000, q.req_err, q.mode_err,
                                          q.st != S_IDLE, q.done};
                default: begin
                    if (REG_ADDR[7:5] == `SDC_BUF_PAGE) d.rdata = {16'h0000, q.dbuf[REG_ADDR[4:2]]};
                end
            endcase
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            q           <= '0;
            q.st        <= S_POWER;
            q.ret       <= S_IDLE;
            q.mode_pend <= `SDC_MODE_RST;
            q.cmd       <= `SDC_CMD_INHIBIT;
            q.dqm       <= 1'b1;
        end else if (CE) begin
            q <= d;
        end
    end

    assign REG_RDATA = q.rdata;
    assign SD_CKE    = q.cke;
    assign {SD_CS_N, SD_RAS_N, SD_CAS_N, SD_WE_N} = q.cmd;
    assign SD_BA     = q.ba;
    assign SD_A      = q.a;
    assign SD_DQM    = q.dqm;
    assign SD_DQ_O   = q.dq_o;
    assign SD_DQ_OE  = q.dq_oe;

    ////////////////////////////////////////////////////////////////////////////
    // Checks on the pins this controller drives

    logic [3:0]  cmd_now;
    logic [15:0] pu_cnt;
    logic [1:0]  ref_seen;
    logic        bank_open;
    logic        loaded;
    logic        any_cmd;

    assign cmd_now = {SD_CS_N, SD_RAS_N, SD_CAS_N, SD_WE_N};

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            pu_cnt    <= 16'h0000;
            ref_seen  <= 2'h0;
            bank_open <= 1'b0;
            loaded    <= 1'b0;
            any_cmd   <= 1'b0;
        end else if (CE) begin
            if (pu_cnt != 16'hFFFF) pu_cnt <= pu_cnt + 16'h0001;
            if (cmd_now == `SDC_CMD_REF && ref_seen != 2'h3) ref_seen <= ref_seen + 2'h1;
            if (cmd_now == `SDC_CMD_ACTIVE) bank_open <= 1'b1;
            if (cmd_now == `SDC_CMD_PRE && SD_A[10]) bank_open <= 1'b0;
            if (cmd_now == `SDC_CMD_LMR) loaded <= 1'b1;
            if (cmd_now != `SDC_CMD_NOP && cmd_now != `SDC_CMD_INHIBIT) any_cmd <= 1'b1;
        end
    end

    default clocking dclk @(posedge SYS_CLK); endclocking
    default disable iff (RST);

    sequence s_load_cmd;
        CE && cmd_now == `SDC_CMD_LMR;
    endsequence
    sequence s_quiet;
        cmd_now == `SDC_CMD_NOP;
    endsequence

    a_power_wait_quiet: assert property (
        (cmd_now != `SDC_CMD_NOP && cmd_now != `SDC_CMD_INHIBIT)
            |-> pu_cnt >= 16'(P_POWER_CYC))
        else $error("Command issued before power-up wait ended");
    a_first_prech_all: assert property (
        (!any_cmd && cmd_now != `SDC_CMD_NOP && cmd_now != `SDC_CMD_INHIBIT)
            |-> cmd_now == `SDC_CMD_PRE && SD_A[10])
        else $error("First command after power-up is not precharge-all");
    a_refresh_before_load: assert property (
        s_load_cmd |-> ref_seen >= 2'h2)
        else $error("Mode load before two refreshes");
    a_mode_clean_bits: assert property (
        s_load_cmd |-> SD_BA == 2'h0 && SD_A[12:10] == 3'h0)
        else $error("Mode load with high op-code bits set");
    a_mode_legal_code: assert property (
        s_load_cmd |-> mode_legal({1'b0, SD_A}))
        else $error("Mode load with reserved field encoding");
    a_load_idle_gap: assert property (
        s_load_cmd |-> !bank_open ##1 s_quiet)
        else $error("Mode load while open or without load delay");
    a_access_after_act: assert property (
        (cmd_now == `SDC_CMD_READ || cmd_now == `SDC_CMD_WRITE) |-> bank_open)
        else $error("Access without preceding activate");
    a_ops_after_mode: assert property (
        (cmd_now == `SDC_CMD_ACTIVE) |-> loaded)
        else $error("Activate before mode register loaded");
    a_refresh_cke_high: assert property (
        (cmd_now == `SDC_CMD_REF) |-> SD_CKE && $stable(SD_CKE))
        else $error("Refresh issued with clock enable low");

endmodule

//--- src/sdc_pkg.sv
package sdc_pkg;

    typedef enum logic [3:0] {
        S_POWER, S_PREALL, S_REFRESH, S_LOAD, S_IDLE,
        S_ACTIVE, S_ACCESS, S_RDATA, S_WDATA, S_CLOSE, S_WAIT
    } sdc_state_t;

    typedef struct packed {
        sdc_state_t       st;
        sdc_state_t       ret;
        logic [15:0]      cnt;
        logic [1:0]       refs;
        logic [3:0]       beat;
        logic [13:0]      mode_pend;
        logic [13:0]      mode_act;
        logic             done;
        logic             mode_err;
        logic             req_err;
        logic             is_wr;
        logic [1:0]       bank;
        logic [12:0]      row;
        logic [9:0]       col;
        logic [7:0][15:0] dbuf;
        logic [31:0]      rdata;
        logic             cke;
        logic [3:0]       cmd;
        logic [1:0]       ba;
        logic [12:0]      a;
        logic             dqm;
        logic [15:0]      dq_o;
        logic             dq_oe;
    } sdc_regs_t;

endpackage
